// ==== hdl/spb_pkg.sv ====
// shared constants, encodings and pin bundles for the secondary bus ends
package spb_pkg;

  // ********************************************************
  // address decode and timing
  // ********************************************************
  localparam logic [31:0] BRG_BASE    = 32'h0001_0000; // bridge target window
  localparam logic [31:0] AGT_BASE    = 32'h0002_0000; // agent target window
  localparam logic [31:0] WIN_MASK    = 32'hffff_0000; // 64 KiB windows
  localparam logic [2:0]  MABORT_CYC  = 3'h5;          // cycles without select
  localparam logic [3:0]  CMD_MEM_RD  = 4'h6;          // memory read
  localparam logic [3:0]  CMD_MEM_WR  = 4'h7;          // memory write
  localparam logic        PREQ_RST_N  = 1'h1;          // request idle after reset
  localparam logic        GNT_RST_N   = 1'h1;          // grant idle after reset
  localparam logic        FRAME_RST_N = 1'h1;          // last frame seen idle

  // ********************************************************
  // state and code enumerations
  // ********************************************************
  typedef enum logic [1:0] {
    INI_IDLE = 2'b00, INI_ADDR = 2'b01, INI_DATA = 2'b10, INI_TURN = 2'b11
  } spb_ini_e;
  typedef enum logic [1:0] {
    TGT_IDLE = 2'b00, TGT_WAIT = 2'b01, TGT_DATA = 2'b10, TGT_TURN = 2'b11
  } spb_tgt_e;
  typedef enum logic [1:0] {
    TERM_NORMAL = 2'b00, TERM_DISC = 2'b01, TERM_RETRY = 2'b10, TERM_ABORT = 2'b11
  } spb_term_e;
  typedef enum logic [2:0] {
    ST_OK = 3'b000, ST_DISC = 3'b001, ST_RETRY = 3'b010, ST_TABORT = 3'b011,
    ST_MABORT = 3'b100
  } spb_stat_e;

  // ********************************************************
  // shared bus lines, value and enable
  // ********************************************************
  typedef struct packed {
    logic [31:0] ad;
    logic [3:0]  secondary_cmd_byte_en_n;
    logic        secondary_parity;
    logic        frame_n;
    logic        secondary_initiator_ready_n;
    logic        secondary_target_ready_n;
    logic        secondary_device_select_n;
    logic        stop_n;
    logic        lock_n;
  } spb_pins_s;
  typedef struct packed {
    logic ad, cbe, par, frame, irdy, trdy, devsel, stop, lock;
  } spb_oe_s;

endpackage

// ==== hdl/spb_bus_if.sv ====
// secondary bus wiring between bridge end and agent end, with pull-ups
`timescale 1ns/1ps
interface spb_bus_if;
  spb_pkg::spb_pins_s brg_o;        // bridge drive values
  spb_pkg::spb_oe_s   brg_oe;       // bridge enables
  spb_pkg::spb_pins_s agt_o;        // agent drive values
  spb_pkg::spb_oe_s   agt_oe;       // agent enables
  spb_pkg::spb_pins_s sec;          // resolved line levels
  logic               prim_req_n;   // primary request, bridge to arbiter
  logic               prim_grant_n; // primary grant, arbiter to bridge

  // widen per-line enables into a bit mask
  function automatic logic [42:0] spb_mask(input spb_pkg::spb_oe_s e);
    spb_mask = {{32{e.ad}}, {4{e.cbe}}, e.par, e.frame, e.irdy, e.trdy, e.devsel, e.stop, e.lock};
  endfunction

  // undriven lines read high, as the pull-ups hold them
  assign sec = (brg_o & spb_mask(brg_oe)) | (agt_o & spb_mask(agt_oe))
             | ~(spb_mask(brg_oe) | spb_mask(agt_oe));

  modport bridge (input sec, input prim_grant_n, output brg_o, output brg_oe, output prim_req_n);
  modport agent  (input sec, input prim_req_n, output agt_o, output agt_oe, output prim_grant_n);
endinterface

// ==== hdl/spb_agent_end.sv ====
// far end: other secondary initiator/target plus primary arbiter grant
`timescale 1ns/1ps
module spb_agent_end (
  input  wire logic                 mclk,       // bus clock
  input  wire logic                 rst_n,      // sync reset
  spb_bus_if.agent                  bus,        // shared lines
  input  wire logic                 arb_allow,  // arbiter may grant
  input  wire logic                 ini_req,    // start a transaction
  input  wire logic                 ini_write,  // write when high
  input  wire logic [31:0]          ini_addr,   // target address
  input  wire logic [31:0]          ini_data,   // write data
  input  wire logic [3:0]           ini_be_n,   // byte enables
  output logic                      ini_done,   // end pulse
  output spb_pkg::spb_stat_e        ini_status, // how it ended
  output logic [31:0]               ini_rdata,  // read data
  input  spb_pkg::spb_term_e        tgt_term,   // target answer mode
  input  wire logic [31:0]          tgt_rdata,  // data to return
  output logic                      tgt_rd,     // read data taken
  output logic                      tgt_wr,     // write data valid
  output logic [31:0]               tgt_addr,   // claimed address
  output logic [31:0]               tgt_wdata,  // written data
  output logic [3:0]                tgt_be_n    // written enables
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    spb_pkg::spb_ini_e  ist;     // initiator state
    spb_pkg::spb_tgt_e  tst;     // target state
    spb_pkg::spb_pins_s pin;     // line values
    spb_pkg::spb_oe_s   oe;      // line enables
    logic [2:0]         cnt;     // select wait count
    logic               fprev_n; // frame last cycle
    spb_pkg::spb_term_e mode;    // latched answer mode
    logic               t_write; // claimed cycle writes
    logic               grant_n; // primary grant
    logic               done;
    spb_pkg::spb_stat_e stat;
    logic [31:0]        rdata;
    logic               t_rd;
    logic               t_wr;
    logic [31:0]        t_addr;
    logic [31:0]        t_wdata;
    logic [3:0]         t_be;
  } spb_agt_s;

  spb_agt_s           q;   // registered state
  spb_agt_s           d;   // next state
  spb_pkg::spb_pins_s b;   // resolved lines
  logic               xfer; // data phase completes

  assign b    = bus.sec;
  assign xfer = ~b.secondary_initiator_ready_n & ~b.secondary_target_ready_n;

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    d = q;
    d.done    = 1'b0;
    d.t_rd    = 1'b0;
    d.t_wr    = 1'b0;
    d.fprev_n = b.frame_n;
    // parity one cycle behind whatever we put on ad
    d.pin.secondary_parity = ^{b.ad, b.secondary_cmd_byte_en_n};
    d.oe.par  = q.oe.ad;
    // grant only to a live request
    d.grant_n = ~(arb_allow & ~bus.prim_req_n);
    unique case (q.ist)
      spb_pkg::INI_IDLE: begin
        if (ini_req && b.frame_n && b.secondary_initiator_ready_n && q.tst == spb_pkg::TGT_IDLE) begin
          d.ist = spb_pkg::INI_ADDR;
          d.pin.frame_n = 1'b0;
          d.pin.ad = ini_addr;
          d.pin.secondary_cmd_byte_en_n = ini_write ? spb_pkg::CMD_MEM_WR : spb_pkg::CMD_MEM_RD;
          d.oe.frame = 1'b1;
          d.oe.ad    = 1'b1;
          d.oe.cbe   = 1'b1;
        end
      end
      spb_pkg::INI_ADDR: begin
        // one data phase, so frame rises with ready
        d.ist = spb_pkg::INI_DATA;
        d.pin.frame_n = 1'b1;
        d.pin.secondary_initiator_ready_n = 1'b0;
        d.oe.irdy = 1'b1;
        d.pin.secondary_cmd_byte_en_n = ini_be_n;
        d.pin.ad = ini_data;
        d.oe.ad  = ini_write;
        d.cnt    = 3'h0;
      end
      spb_pkg::INI_DATA: begin
        d.cnt = q.cnt + 3'h1;
        if (xfer || !b.stop_n || (b.secondary_device_select_n && q.cnt == spb_pkg::MABORT_CYC)) begin
          d.ist  = spb_pkg::INI_TURN;
          d.done = 1'b1;
          d.rdata = b.ad;
          if (xfer)
            d.stat = b.stop_n ? spb_pkg::ST_OK : spb_pkg::ST_DISC;
          else if (!b.stop_n)
            d.stat = b.secondary_device_select_n ? spb_pkg::ST_TABORT : spb_pkg::ST_RETRY;
          else
            d.stat = spb_pkg::ST_MABORT;
          d.pin.secondary_initiator_ready_n = 1'b1;
          d.oe.frame = 1'b0;
          d.oe.ad    = 1'b0;
          d.oe.cbe   = 1'b0;
        end
      end
      spb_pkg::INI_TURN: begin
        d.ist = spb_pkg::INI_IDLE;
        d.oe.irdy = 1'b0;
      end
    endcase
    unique case (q.tst)
      spb_pkg::TGT_IDLE: begin
        if (!b.frame_n && q.fprev_n && q.ist == spb_pkg::INI_IDLE
            && (b.ad & spb_pkg::WIN_MASK) == spb_pkg::AGT_BASE) begin
          d.tst     = spb_pkg::TGT_WAIT;
          d.mode    = tgt_term;
          d.t_write = b.secondary_cmd_byte_en_n[0];
          d.t_addr  = b.ad;
          d.pin.secondary_device_select_n = (tgt_term == spb_pkg::TERM_ABORT);
          d.pin.secondary_target_ready_n  = 1'b1;
          d.pin.stop_n = 1'b1;
          d.oe.devsel  = 1'b1;
          d.oe.trdy    = 1'b1;
          d.oe.stop    = 1'b1;
        end
      end
      spb_pkg::TGT_WAIT: begin
        d.tst = spb_pkg::TGT_DATA;
        d.pin.secondary_target_ready_n = (q.mode == spb_pkg::TERM_RETRY) || (q.mode == spb_pkg::TERM_ABORT);
        d.pin.stop_n = (q.mode == spb_pkg::TERM_NORMAL);
        d.pin.ad = tgt_rdata;
        d.oe.ad  = ~q.t_write;
        d.t_rd   = ~q.t_write;
      end
      spb_pkg::TGT_DATA: begin
        if (xfer && q.t_write) begin
          d.t_wr    = 1'b1;
          d.t_wdata = b.ad;
          d.t_be    = b.secondary_cmd_byte_en_n;
        end
        if (!b.secondary_initiator_ready_n && (xfer || !b.stop_n) && b.frame_n) begin
          d.tst = spb_pkg::TGT_TURN;
          d.pin.secondary_device_select_n = 1'b1;
          d.pin.secondary_target_ready_n  = 1'b1;
          d.pin.stop_n = 1'b1;
          d.oe.ad = 1'b0;
        end else if (xfer && !b.stop_n) begin
          d.pin.secondary_target_ready_n = 1'b1;
        end else if (xfer && !q.t_write) begin
          d.pin.ad = tgt_rdata;
          d.t_rd   = 1'b1;
        end
      end
      spb_pkg::TGT_TURN: begin
        d.tst = spb_pkg::TGT_IDLE;
        d.oe.devsel = 1'b0;
        d.oe.trdy   = 1'b0;
        d.oe.stop   = 1'b0;
      end
    endcase
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q         <= '0;
      q.grant_n <= spb_pkg::GNT_RST_N;
      q.fprev_n <= spb_pkg::FRAME_RST_N;
    end else begin
      q <= d;
    end
  end

  assign bus.agt_o        = q.pin;
  assign bus.agt_oe       = q.oe;
  assign bus.prim_grant_n = q.grant_n;
  assign ini_done         = q.done;
  assign ini_status       = q.stat;
  assign ini_rdata        = q.rdata;
  assign tgt_rd           = q.t_rd;
  assign tgt_wr           = q.t_wr;
  assign tgt_addr         = q.t_addr;
  assign tgt_wdata        = q.t_wdata;
  assign tgt_be_n         = q.t_be;

endmodule // spb_agent_end

// ==== hdl/spb_bridge_end.sv ====
// bridge end: secondary initiator and target, lock, primary request
`timescale 1ns/1ps

// ********************************************************
// bridge secondary bus end
// ********************************************************
// Overview of operation
// - request primary bus by driving request low
// - own primary only after grant and idle
// - ad carries address, then data
// - cbe carries command, then byte enables
// - parity is even over ad and cbe
// - parity lags its transfer by one clock
// - drive parity whenever we drive ad
// - frame starts transaction, rises for last phase
// - phase completes when both readies sampled low
// - each ready asserted only when able
// - initiator ends transaction when stop seen
// - stop with ready and select: disconnect data
// - stop and select, no ready: retry
// - stop without select means target abort
// - stop driven high one clock, then released
// - lock high at address, low next clock
module spb_bridge_end (
  input  wire logic                 mclk,       // bus clock
  input  wire logic                 rst_n,      // sync reset
  spb_bus_if.bridge                 bus,        // shared lines
  input  wire logic                 prim_want,  // want primary bus
  input  wire logic                 prim_idle,  // primary transfer done
  output logic                      prim_owned, // primary bus is ours
  input  wire logic                 ini_req,    // start a transaction
  input  wire logic                 ini_write,  // write when high
  input  wire logic                 ini_lock,   // locked transaction
  input  wire logic [31:0]          ini_addr,   // target address
  input  wire logic [31:0]          ini_data,   // write data
  input  wire logic [3:0]           ini_be_n,   // byte enables
  output logic                      ini_done,   // end pulse
  output spb_pkg::spb_stat_e        ini_status, // how it ended
  output logic [31:0]               ini_rdata,  // read data
  input  spb_pkg::spb_term_e        tgt_term,   // target answer mode
  input  wire logic [31:0]          tgt_rdata,  // data to return
  output logic                      tgt_rd,     // read data taken
  output logic                      tgt_wr,     // write data valid
  output logic [31:0]               tgt_addr,   // claimed address
  output logic [31:0]               tgt_wdata,  // written data
  output logic [3:0]                tgt_be_n    // written enables
);

  // ********************************************************
  // state
  // ********************************************************
  typedef struct packed {
    spb_pkg::spb_ini_e  ist;      // initiator state
    spb_pkg::spb_tgt_e  tst;      // target state
    spb_pkg::spb_pins_s pin;      // line values
    spb_pkg::spb_oe_s   oe;       // line enables
    logic [2:0]         cnt;      // select wait count
    logic               fprev_n;  // frame last cycle
    spb_pkg::spb_term_e mode;     // latched answer mode
    logic               t_write;  // claimed cycle writes
    logic               lock_act; // lock held downstream
    logic               lock_rel; // lock driving high once
    logic               preq_n;   // primary request
    logic               owned;    // primary ownership
    logic               done;
    spb_pkg::spb_stat_e stat;
    logic [31:0]        rdata;
    logic               t_rd;
    logic               t_wr;
    logic [31:0]        t_addr;
    logic [31:0]        t_wdata;
    logic [3:0]         t_be;
  } spb_brg_s;

  spb_brg_s           q;    // registered state
  spb_brg_s           d;    // next state
  spb_pkg::spb_pins_s b;    // resolved lines
  logic               xfer; // data phase completes

  assign b    = bus.sec;
  // a phase counts only on an edge where both readies are low
  assign xfer = ~b.secondary_initiator_ready_n & ~b.secondary_target_ready_n;

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    d = q;
    d.done     = 1'b0;
    d.t_rd     = 1'b0;
    d.t_wr     = 1'b0;
    d.lock_rel = 1'b0;
    d.fprev_n  = b.frame_n;
    // parity over the lines as seen, so it fits whoever drove cbe
    d.pin.secondary_parity = ^{b.ad, b.secondary_cmd_byte_en_n};
    // enable trails ad by one clock, giving parity its own turnaround
    d.oe.par = q.oe.ad;
    // primary side: request level, ownership once granted and quiet
    d.preq_n = ~prim_want;
    d.owned  = prim_want & (q.owned | (~bus.prim_grant_n & prim_idle));
    // lock release: one clock high already driven, now let go
    if (q.lock_rel)
      d.oe.lock = 1'b0;

    // ---------- initiator ----------
    unique case (q.ist)
      spb_pkg::INI_IDLE: begin
        // waits for a quiet bus and an idle target side
        if (ini_req && b.frame_n && b.secondary_initiator_ready_n && q.tst == spb_pkg::TGT_IDLE) begin
          d.ist = spb_pkg::INI_ADDR;
          d.pin.frame_n = 1'b0;
          d.pin.ad = ini_addr;
          d.pin.secondary_cmd_byte_en_n = ini_write ? spb_pkg::CMD_MEM_WR : spb_pkg::CMD_MEM_RD;
          d.oe.frame = 1'b1;
          d.oe.ad    = 1'b1;
          d.oe.cbe   = 1'b1;
          if (ini_lock) begin
            d.pin.lock_n = 1'b1;
            d.oe.lock    = 1'b1;
          end
        end else if (q.lock_act && !ini_lock) begin
          // release lock with one high clock before the pull-up
          d.pin.lock_n = 1'b1;
          d.oe.lock    = 1'b1;
          d.lock_act   = 1'b0;
          d.lock_rel   = 1'b1;
        end
      end
      spb_pkg::INI_ADDR: begin
        // single data phase: frame rises as ready falls
        d.ist = spb_pkg::INI_DATA;
        d.pin.frame_n = 1'b1;
        d.pin.secondary_initiator_ready_n = 1'b0;
        d.oe.irdy = 1'b1;
        d.pin.secondary_cmd_byte_en_n = ini_be_n;
        d.pin.ad = ini_data;
        d.oe.ad  = ini_write;
        d.cnt    = 3'h0;
        if (ini_lock) begin
          d.pin.lock_n = 1'b0;
          d.lock_act   = 1'b1;
        end
      end
      spb_pkg::INI_DATA: begin
        d.cnt = q.cnt + 3'h1;
        // ends on data, on stop, or when nobody selects in time
        if (xfer || !b.stop_n || (b.secondary_device_select_n && q.cnt == spb_pkg::MABORT_CYC)) begin
          d.ist   = spb_pkg::INI_TURN;
          d.done  = 1'b1;
          d.rdata = b.ad;
          if (xfer)
            d.stat = b.stop_n ? spb_pkg::ST_OK : spb_pkg::ST_DISC;
          else if (!b.stop_n)
            d.stat = b.secondary_device_select_n ? spb_pkg::ST_TABORT : spb_pkg::ST_RETRY;
          else
            d.stat = spb_pkg::ST_MABORT;
          d.pin.secondary_initiator_ready_n = 1'b1;
          d.oe.frame = 1'b0;
          d.oe.ad    = 1'b0;
          d.oe.cbe   = 1'b0;
        end
      end
      spb_pkg::INI_TURN: begin
        // ready was driven high for one clock; hand it to the pull-up
        d.ist = spb_pkg::INI_IDLE;
        d.oe.irdy = 1'b0;
      end
    endcase

    // ---------- target ----------
    unique case (q.tst)
      spb_pkg::TGT_IDLE: begin
        // address phase is the first clock of frame low, not our own
        if (!b.frame_n && q.fprev_n && q.ist == spb_pkg::INI_IDLE
            && (b.ad & spb_pkg::WIN_MASK) == spb_pkg::BRG_BASE) begin
          d.tst     = spb_pkg::TGT_WAIT;
          d.mode    = tgt_term;
          d.t_write = b.secondary_cmd_byte_en_n[0];
          d.t_addr  = b.ad;
          d.pin.secondary_device_select_n = (tgt_term == spb_pkg::TERM_ABORT);
          d.pin.secondary_target_ready_n  = 1'b1;
          d.pin.stop_n = 1'b1;
          d.oe.devsel  = 1'b1;
          d.oe.trdy    = 1'b1;
          d.oe.stop    = 1'b1;
        end
      end
      spb_pkg::TGT_WAIT: begin
        // one wait clock always: covers the ad turnaround on reads
        d.tst = spb_pkg::TGT_DATA;
        d.pin.secondary_target_ready_n = (q.mode == spb_pkg::TERM_RETRY) || (q.mode == spb_pkg::TERM_ABORT);
        d.pin.stop_n = (q.mode == spb_pkg::TERM_NORMAL);
        d.pin.ad = tgt_rdata;
        d.oe.ad  = ~q.t_write;
        d.t_rd   = ~q.t_write;
      end
      spb_pkg::TGT_DATA: begin
        if (xfer && q.t_write) begin
          d.t_wr    = 1'b1;
          d.t_wdata = b.ad;
          d.t_be    = b.secondary_cmd_byte_en_n;
        end
        if (!b.secondary_initiator_ready_n && (xfer || !b.stop_n) && b.frame_n) begin
          // last phase done: drive high one clock, then release
          d.tst = spb_pkg::TGT_TURN;
          d.pin.secondary_device_select_n = 1'b1;
          d.pin.secondary_target_ready_n  = 1'b1;
          d.pin.stop_n = 1'b1;
          d.oe.ad = 1'b0;
        end else if (xfer && !b.stop_n) begin
          // disconnect moved its one word; no more ready
          d.pin.secondary_target_ready_n = 1'b1;
        end else if (xfer && !q.t_write) begin
          d.pin.ad = tgt_rdata;
          d.t_rd   = 1'b1;
        end
      end
      spb_pkg::TGT_TURN: begin
        d.tst = spb_pkg::TGT_IDLE;
        d.oe.devsel = 1'b0;
        d.oe.trdy   = 1'b0;
        d.oe.stop   = 1'b0;
      end
    endcase
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q         <= '0;
      q.preq_n  <= spb_pkg::PREQ_RST_N;
      q.fprev_n <= spb_pkg::FRAME_RST_N;
    end else begin
      q <= d;
    end
  end

  assign bus.brg_o      = q.pin;
  assign bus.brg_oe     = q.oe;
  assign bus.prim_req_n = q.preq_n;
  assign prim_owned     = q.owned;
  assign ini_done       = q.done;
  assign ini_status     = q.stat;
  assign ini_rdata      = q.rdata;
  assign tgt_rd         = q.t_rd;
  assign tgt_wr         = q.t_wr;
  assign tgt_addr       = q.t_addr;
  assign tgt_wdata      = q.t_wdata;
  assign tgt_be_n       = q.t_be;

endmodule // spb_bridge_end

// ==== sim/spb_bus_props.sv ====
// concurrent checks on the lines shared by bridge and agent
`timescale 1ns/1ps
module spb_bus_props (
  input wire logic          mclk,
  input wire logic          rst_n,
  input spb_pkg::spb_pins_s sec,
  input spb_pkg::spb_oe_s   brg_oe,
  input spb_pkg::spb_oe_s   agt_oe,
  input wire logic          prim_req_n,
  input wire logic          prim_grant_n
);
  // ****************
  // bus properties
  // ****************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire ir_n = sec.secondary_initiator_ready_n; // short alias
  // lock stays high in the address phase
  sequence s_lock_addr;
    sec.lock_n && !sec.frame_n;
  endsequence
  sequence s_lock_on;
    !sec.lock_n;
  endsequence
  a_par_even: assert property ((brg_oe.par || agt_oe.par) |->
    sec.secondary_parity == ^{$past(sec.ad), $past(sec.secondary_cmd_byte_en_n)}) else $error("parity wrong");
  a_par_follow: assert property (brg_oe.ad |=> brg_oe.par) else $error("parity not driven");
  a_grant_req: assert property (!prim_grant_n |-> $past(!prim_req_n)) else $error("grant unasked");
  a_stop_once: assert property (brg_oe.stop && sec.stop_n && ir_n && sec.frame_n |=> !brg_oe.stop)
    else $error("stop held");
  a_lock_late: assert property ($rose(brg_oe.lock) |-> s_lock_addr ##1 s_lock_on) else $error("lock early");
  // lock must be driven high for a clock before the pull-up takes it
  a_lock_free: assert property ($fell(brg_oe.lock) |-> $past(sec.lock_n)) else $error("lock not high");
  a_irdy_turn: assert property ($fell(brg_oe.irdy) |-> $past(ir_n)) else $error("irdy no turn");
  a_no_fight: assert property (!(brg_oe.ad && agt_oe.ad)) else $error("ad contention");
  a_frame_last: assert property ($fell(sec.frame_n) |=> sec.frame_n && !ir_n) else $error("frame long");
  a_irdy_hold: assert property (!ir_n && sec.secondary_target_ready_n && sec.stop_n
    && !sec.secondary_device_select_n |=> !ir_n) else $error("irdy dropped");
endmodule // spb_bus_props

// ==== sim/secondary_pci_bus_signaling_tb.sv ====
// bench joining bridge and agent ends over the shared bus
`timescale 1ns/1ps
module secondary_pci_bus_signaling_tb;
  logic mclk = 1'b0, rst_n = 1'b0, want = 1'b0, idle = 1'b0, allow = 1'b0, lk = 1'b0;
  logic b_req = 1'b0, a_req = 1'b0, wr = 1'b0, owned, b_done, a_done;
  logic [31:0] addr = 32'h0, data = 32'h0, rdata = 32'h0, b_rd, a_rd, b_twd, a_twd;
  logic [3:0] be = 4'h0, b_tbe, a_tbe;
  logic b_tw, a_tw, b_trd, a_trd;
  logic [31:0] b_ta, a_ta;
  spb_pkg::spb_term_e term = spb_pkg::TERM_NORMAL;
  spb_pkg::spb_stat_e b_st, a_st;
  int err_count = 0, checks_done = 0;
  spb_bus_if bus ();
  always #12.5 mclk = ~mclk;
  spb_bridge_end i_spb_bridge_end (.mclk, .rst_n, .bus(bus.bridge), .prim_want(want), .prim_idle(idle),
    .prim_owned(owned), .ini_req(b_req), .ini_write(wr), .ini_lock(lk), .ini_addr(addr), .ini_data(data),
    .ini_be_n(be), .ini_done(b_done), .ini_status(b_st), .ini_rdata(b_rd), .tgt_term(term),
    .tgt_rdata(rdata), .tgt_rd(b_trd), .tgt_wr(b_tw), .tgt_addr(b_ta), .tgt_wdata(b_twd), .tgt_be_n(b_tbe));
  spb_agent_end i_spb_agent_end (.mclk, .rst_n, .bus(bus.agent), .arb_allow(allow), .ini_req(a_req),
    .ini_write(wr), .ini_addr(addr), .ini_data(data), .ini_be_n(be), .ini_done(a_done), .ini_status(a_st),
    .ini_rdata(a_rd), .tgt_term(term), .tgt_rdata(rdata), .tgt_rd(a_trd), .tgt_wr(a_tw), .tgt_addr(a_ta),
    .tgt_wdata(a_twd), .tgt_be_n(a_tbe));
  spb_bus_props i_spb_bus_props (.mclk, .rst_n, .sec(bus.sec), .brg_oe(bus.brg_oe), .agt_oe(bus.agt_oe),
    .prim_req_n(bus.prim_req_n), .prim_grant_n(bus.prim_grant_n));
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one transaction; side high means the agent starts it
  task automatic xfer(input logic side, w, input logic [31:0] a, input spb_pkg::spb_term_e t,
                      input spb_pkg::spb_stat_e es);
    logic dn, wp, rp;
    @(negedge mclk);
    wr = w;
    addr = a;
    term = t;
    data = data + 32'h1357_9bdf;
    rdata = ~data;
    be = data[3:0];
    if (side)
      a_req = 1'b1;
    else
      b_req = 1'b1;
    dn = 1'b0;
    wp = 1'b0;
    rp = 1'b0;
    repeat (20) if (!dn) begin
      @(posedge mclk);
      #1;
      dn = side ? a_done : b_done;
      // the far end is the target: its write strobe lands with done
      wp = side ? b_tw : a_tw;
      rp = rp | (side ? b_trd : a_trd);
    end
    @(negedge mclk);
    a_req = 1'b0;
    b_req = 1'b0;
    chk("done", {31'h0, dn}, 32'h1);
    chk("status", {29'h0, side ? a_st : b_st}, {29'h0, es});
    chk("write strobe", {31'h0, wp}, {31'h0, w && es <= spb_pkg::ST_DISC});
    chk("read strobe", {31'h0, rp}, {31'h0, !w && es != spb_pkg::ST_MABORT});
    if (es != spb_pkg::ST_MABORT)
      chk("claimed addr", side ? b_ta : a_ta, a);
    if (es <= spb_pkg::ST_DISC)
      chk("data", w ? (side ? b_twd : a_twd) : (side ? a_rd : b_rd), w ? data : rdata);
    if (w && es <= spb_pkg::ST_DISC)
      chk("byte enables", {28'h0, side ? b_tbe : a_tbe}, {28'h0, be});
    repeat (3) @(negedge mclk);
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    want = 1'b1;
    allow = 1'b1;
    repeat (4) @(negedge mclk);
    chk("request", {31'h0, bus.prim_req_n}, 32'h0);
    chk("owned busy", {31'h0, owned}, 32'h0);
    idle = 1'b1;
    repeat (2) @(negedge mclk);
    chk("owned", {31'h0, owned}, 32'h1);
    for (int i = 0; i < 16; i++)
      xfer(i[0], i[1], (i[0] ? spb_pkg::BRG_BASE : spb_pkg::AGT_BASE) + 32'(i * 4),
           spb_pkg::spb_term_e'(i[3:2]), spb_pkg::spb_stat_e'({1'b0, i[3:2]}));
    xfer(1'b0, 1'b1, 32'h0003_0000, spb_pkg::TERM_NORMAL, spb_pkg::ST_MABORT);
    xfer(1'b1, 1'b0, 32'h0003_0000, spb_pkg::TERM_NORMAL, spb_pkg::ST_MABORT);
    lk = 1'b1;
    xfer(1'b0, 1'b1, spb_pkg::AGT_BASE, spb_pkg::TERM_NORMAL, spb_pkg::ST_OK);
    lk = 1'b0;
    want = 1'b0;
    repeat (4) @(negedge mclk);
    chk("request idle", {31'h0, bus.prim_req_n}, 32'h1);
    chk("owned idle", {31'h0, owned}, 32'h0);
    conclude();
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #200000;
    err_count++;
    conclude();
  end
endmodule // secondary_pci_bus_signaling_tb
